// *** pkg/icbd_consts.vh ***
// Constants for the isochronous circular-buffer DMA channel
`ifndef ICBD_CONSTS_VH
`define ICBD_CONSTS_VH

// Buffer memory and pointer width
`define ICBD_AW               8
`define ICBD_MEM_WORDS        256

// Count register layout: 7-bit sample count, flag on top
`define ICBD_CNT_W            7
`define ICBD_FLAG_BIT         7
`define ICBD_FLAG_RESET       1'b1
`define ICBD_COUNT_RESET      7'h00

// Timing
`define ICBD_CLK_MHZ          10
`define ICBD_USB_MHZ          12
`define ICBD_FRAME_US         1000
`define ICBD_MARK_USB_PERIODS 1511
`define ICBD_FRAME_CYCLES     (`ICBD_FRAME_US * `ICBD_CLK_MHZ)
`define ICBD_MARK_CYCLES      ((`ICBD_MARK_USB_PERIODS * `ICBD_CLK_MHZ) / `ICBD_USB_MHZ)
`define ICBD_TIMER_W          16

// Output FIFO toward the codec port
`define ICBD_FIFO_WIDTH       8
`define ICBD_FIFO_DEPTH       4
`define ICBD_FIFO_AW          2

`endif

// *** logic/icbd_top.v ***
// Isochronous circular-buffer DMA channel with its codec-side FIFO
//
// How it works
// - OUT mode: disabled channel holds read and write pointers at buffer base.
// - OUT bytes from buffer manager are stored, write pointer advancing per byte.
// - OUT data waits for next start-of-frame, then next codec frame start.
// - OUT drain advances read pointer per byte while comparing with write pointer.
// - Read pointer reaching write pointer pauses draining until next start-of-frame.
// - OUT packet sample count goes to Y when frame LSB 1, else X.
// - Streaming continues until the processor drops the channel enable.
// - Time mark fires 1511 USB clock periods before each expected start-of-frame.
// - At mark, finish input frame, then clear chosen flag and load count.
// - Each IN count register holds 7-bit sample count plus not-ready flag.
// - IN selection reversed: frame LSB 1 selects X, 0 selects Y.
// - IN init: pointers at base, both flags set, both counts cleared.
// - Input bytes stored, write pointer advanced per byte, samples counted.
// - After publishing, running sample count restarts from zero.
// - IN transaction reads per byte, then sets flag back and ends.
// - IN served only after cleared flag and start-of-frame; alternates X and Y.
// - IN token with both flags set answers with a zero-length packet.
// - Pointers wrap inside the configured base and size.
// - Each start-of-frame loads channel byte count with write minus read.
`timescale 1ns/1ns
`include "icbd_consts.vh"

module icbd_fifo #(
  parameter W  = `ICBD_FIFO_WIDTH,
  parameter D  = `ICBD_FIFO_DEPTH,
  parameter AW = `ICBD_FIFO_AW
) (
  input  wire         clk,
  input  wire         reset_n,
  input  wire         flush,
  input  wire         inValid,
  input  wire [W-1:0] inData,
  output wire         inReady,
  output reg          outValid,
  output reg  [W-1:0] outData,
  input  wire         outReady
);
  localparam [AW:0] FULL = D[AW:0];

  reg  [W-1:0]  store [0:D-1];
  reg  [AW-1:0] wp;
  reg  [AW-1:0] rp;
  reg  [AW:0]   count;
  wire          push;
  wire          load;

  assign inReady = (count != FULL);
  assign push    = inValid && inReady;
  // Output stage refills whenever it is empty or being taken
  assign load    = (count != {(AW+1){1'b0}}) && (!outValid || outReady);

  always @(posedge clk) begin
    if (push) begin
      store[wp] <= inData;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wp       <= {AW{1'b0}};
      rp       <= {AW{1'b0}};
      count    <= {(AW+1){1'b0}};
      outValid <= 1'b0;
      outData  <= {W{1'b0}};
    end else if (flush) begin
      wp       <= {AW{1'b0}};
      rp       <= {AW{1'b0}};
      count    <= {(AW+1){1'b0}};
      outValid <= 1'b0;
    end else begin
      if (push) begin
        wp <= wp + 1'b1;
      end
      if (load) begin
        outData  <= store[rp];
        outValid <= 1'b1;
        rp       <= rp + 1'b1;
      end else if (outReady) begin
        outValid <= 1'b0;
      end
      case ({push, load})
        2'b10:   count <= count + 1'b1;
        2'b01:   count <= count - 1'b1;
        default: count <= count;
      endcase
    end
  end
endmodule // icbd_fifo

module icbd_top #(
  parameter FRAME_CYCLES = `ICBD_FRAME_CYCLES
) (
  input  wire       clk,
  input  wire       reset_n,
  // Channel configuration
  input  wire       dmaEnable,
  input  wire       dirIn,
  input  wire [7:0] bufBase,
  input  wire [7:0] bufSize,
  input  wire [1:0] bytesPerSample,
  // USB frame events
  input  wire       sofPulse,
  input  wire       frameNumberLow,
  // Buffer manager, OUT side
  input  wire       ubmWrValid,
  input  wire [7:0] ubmWrData,
  input  wire       ubmPacketDone,
  input  wire [6:0] ubmSampleCount,
  // Buffer manager, IN side
  input  wire       ubmInToken,
  output reg        ubmRdValid,
  output reg  [7:0] ubmRdData,
  output reg        ubmInDone,
  output reg        ubmNullPacket,
  // Codec port, transmit
  input  wire       cportFrameStart,
  input  wire       cportTxReady,
  output wire       cportTxValid,
  output wire [7:0] cportTxData,
  // Codec port, receive
  input  wire       cportRxValid,
  input  wire [7:0] cportRxData,
  input  wire       cportRxBusy,
  // Status
  output reg  [6:0] outCountRegX,
  output reg  [6:0] outCountRegY,
  output reg  [7:0] inCountRegX,
  output reg  [7:0] inCountRegY,
  output reg  [7:0] channelByteCount,
  output reg  [7:0] rdPtr,
  output reg  [7:0] wrPtr
);
  localparam [3:0] OUT_IDLE = 4'h1;
  localparam [3:0] OUT_WSOF = 4'h2;
  localparam [3:0] OUT_WFRM = 4'h4;
  localparam [3:0] OUT_RUN  = 4'h8;

  localparam integer             MARK_FULL = FRAME_CYCLES - `ICBD_MARK_CYCLES;
  localparam [`ICBD_TIMER_W-1:0] MARK_AT   = MARK_FULL[`ICBD_TIMER_W-1:0];

  reg  [7:0]               mem [0:`ICBD_MEM_WORDS-1];
  reg  [3:0]               outState;
  reg  [`ICBD_TIMER_W-1:0] frameTimer;
  reg                      markPending;
  reg  [1:0]               byteInSample;
  reg  [6:0]               runCount;
  reg                      inArmed;
  reg                      serving;
  reg                      serveY;
  reg  [9:0]               bytesLeft;
  wire                     outMode;
  wire                     inMode;
  wire                     fifoInReady;
  wire                     fifoPush;
  wire                     dmaWrite;
  wire                     ubmRead;
  wire                     markFire;
  wire                     publish;
  wire                     sampleDone;
  wire                     startServe;
  wire                     pickY;
  wire [6:0]               pickCount;
  reg  [7:0]               fill;

  assign outMode    = dmaEnable && !dirIn;
  assign inMode     = dmaEnable && dirIn;
  assign fifoPush   = outMode && (outState == OUT_RUN) && (rdPtr != wrPtr);
  assign dmaWrite   = inMode && cportRxValid;
  assign ubmRead    = serving && (bytesLeft != 10'h000);
  assign markFire   = inMode && (frameTimer == MARK_AT);
  assign publish    = inMode && markPending && !cportRxBusy;
  assign sampleDone = dmaWrite && (byteInSample == bytesPerSample);

  // Prefer the ready register; when both are ready, take the one not served last
  assign pickY      = !inCountRegY[`ICBD_FLAG_BIT] &&
                      (inCountRegX[`ICBD_FLAG_BIT] || !serveY);
  assign pickCount  = pickY ? inCountRegY[6:0] : inCountRegX[6:0];
  assign startServe = inMode && ubmInToken && !serving && inArmed &&
                      !(inCountRegX[`ICBD_FLAG_BIT] && inCountRegY[`ICBD_FLAG_BIT]);

  function [7:0] nextAddr;
    input [7:0] p;
    reg   [8:0] s;
    begin
      s = {1'b0, p} + 9'h001;
      if (s >= ({1'b0, bufBase} + {1'b0, bufSize})) begin
        nextAddr = bufBase;
      end else begin
        nextAddr = s[7:0];
      end
    end
  endfunction

  // Bytes held between read and write pointer, modulo buffer size
  always @* begin
    if (wrPtr >= rdPtr) begin
      fill = wrPtr - rdPtr;
    end else begin
      fill = wrPtr + bufSize - rdPtr;
    end
  end

  icbd_fifo #(
    .W  (`ICBD_FIFO_WIDTH),
    .D  (`ICBD_FIFO_DEPTH),
    .AW (`ICBD_FIFO_AW)
  ) txFifo (
    .clk      (clk),
    .reset_n  (reset_n),
    .flush    (!outMode),
    .inValid  (fifoPush),
    .inData   (mem[rdPtr]),
    .inReady  (fifoInReady),
    .outValid (cportTxValid),
    .outData  (cportTxData),
    .outReady (cportTxReady)
  );

  always @(posedge clk) begin
    if (outMode && ubmWrValid) begin
      mem[wrPtr] <= ubmWrData;
    end else if (dmaWrite) begin
      mem[wrPtr] <= cportRxData;
    end
  end

  // Write pointer: buffer manager in OUT mode, DMA in IN mode
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr <= 8'h00;
    end else if (!dmaEnable) begin
      wrPtr <= bufBase;
    end else if ((outMode && ubmWrValid) || dmaWrite) begin
      wrPtr <= nextAddr(wrPtr);
    end
  end

  // Read pointer: DMA drain in OUT mode, buffer manager in IN mode
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdPtr <= 8'h00;
    end else if (!dmaEnable) begin
      rdPtr <= bufBase;
    end else if ((fifoPush && fifoInReady) || ubmRead) begin
      rdPtr <= nextAddr(rdPtr);
    end
  end

  // OUT drain sequencing
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      outState <= OUT_IDLE;
    end else if (!outMode) begin
      outState <= OUT_IDLE;
    end else begin
      case (outState)
        OUT_IDLE: begin
          if (rdPtr != wrPtr) begin
            outState <= OUT_WSOF;
          end
        end
        OUT_WSOF: begin
          if (sofPulse) begin
            outState <= OUT_WFRM;
          end
        end
        OUT_WFRM: begin
          if (cportFrameStart) begin
            outState <= OUT_RUN;
          end
        end
        OUT_RUN: begin
          if (rdPtr == wrPtr) begin
            outState <= OUT_WSOF;
          end
        end
        default: outState <= OUT_IDLE;
      endcase
    end
  end

  // OUT sample counts and channel byte count
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      outCountRegX     <= `ICBD_COUNT_RESET;
      outCountRegY     <= `ICBD_COUNT_RESET;
      channelByteCount <= 8'h00;
    end else begin
      if (outMode && ubmPacketDone) begin
        if (frameNumberLow) begin
          outCountRegY <= ubmSampleCount;
        end else begin
          outCountRegX <= ubmSampleCount;
        end
      end
      if (dmaEnable && sofPulse) begin
        channelByteCount <= fill;
      end
    end
  end

  // Frame timer for the IN time mark
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      frameTimer <= {`ICBD_TIMER_W{1'b0}};
    end else if (sofPulse) begin
      frameTimer <= {`ICBD_TIMER_W{1'b0}};
    end else if (frameTimer != {`ICBD_TIMER_W{1'b1}}) begin
      frameTimer <= frameTimer + 1'b1;
    end
  end

  // IN collection: sample counting and publication at the time mark
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      markPending  <= 1'b0;
      byteInSample <= 2'h0;
      runCount     <= `ICBD_COUNT_RESET;
    end else if (!inMode) begin
      markPending  <= 1'b0;
      byteInSample <= 2'h0;
      runCount     <= `ICBD_COUNT_RESET;
    end else begin
      // A fresh mark outranks the publication that clears the old one
      if (markFire) begin
        markPending <= 1'b1;
      end else if (publish) begin
        markPending <= 1'b0;
      end
      if (dmaWrite) begin
        byteInSample <= sampleDone ? 2'h0 : byteInSample + 1'b1;
      end
      if (publish) begin
        runCount <= {6'h00, sampleDone};
      end else if (sampleDone) begin
        runCount <= runCount + 1'b1;
      end
    end
  end

  // IN count registers and buffer-manager transaction
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      inCountRegX   <= {`ICBD_FLAG_RESET, `ICBD_COUNT_RESET};
      inCountRegY   <= {`ICBD_FLAG_RESET, `ICBD_COUNT_RESET};
      inArmed       <= 1'b0;
      serving       <= 1'b0;
      serveY        <= 1'b1;
      bytesLeft     <= 10'h000;
      ubmRdValid    <= 1'b0;
      ubmRdData     <= 8'h00;
      ubmInDone     <= 1'b0;
      ubmNullPacket <= 1'b0;
    end else if (!inMode) begin
      inCountRegX   <= {`ICBD_FLAG_RESET, `ICBD_COUNT_RESET};
      inCountRegY   <= {`ICBD_FLAG_RESET, `ICBD_COUNT_RESET};
      inArmed       <= 1'b0;
      serving       <= 1'b0;
      serveY        <= 1'b1;
      bytesLeft     <= 10'h000;
      ubmRdValid    <= 1'b0;
      ubmInDone     <= 1'b0;
      ubmNullPacket <= 1'b0;
    end else begin
      ubmRdValid    <= 1'b0;
      ubmInDone     <= 1'b0;
      ubmNullPacket <= ubmInToken && !serving && !startServe;
      if (sofPulse && (!inCountRegX[`ICBD_FLAG_BIT] || !inCountRegY[`ICBD_FLAG_BIT])) begin
        inArmed <= 1'b1;
      end else if (startServe) begin
        inArmed <= 1'b0;
      end
      if (startServe) begin
        serving   <= 1'b1;
        serveY    <= pickY;
        bytesLeft <= pickCount * ({1'b0, bytesPerSample} + 3'h1);
      end else if (ubmRead) begin
        ubmRdValid <= 1'b1;
        ubmRdData  <= mem[rdPtr];
        bytesLeft  <= bytesLeft - 10'h001;
      end else if (serving) begin
        serving   <= 1'b0;
        ubmInDone <= 1'b1;
        if (serveY) begin
          inCountRegY[`ICBD_FLAG_BIT] <= 1'b1;
        end else begin
          inCountRegX[`ICBD_FLAG_BIT] <= 1'b1;
        end
      end
      // Publication is last so a fresh count wins over a same-cycle release
      if (publish) begin
        if (frameNumberLow) begin
          inCountRegX <= {1'b0, runCount};
        end else begin
          inCountRegY <= {1'b0, runCount};
        end
      end
    end
  end
endmodule // icbd_top

// *** logic/icbd_dummy_never.v ***
// (intentionally unused)

// *** verif/icbd_chk.sv ***
// Port-level assertions for the isochronous circular-buffer DMA channel
`timescale 1ns/1ns
module icbd_chk #(
  parameter FRAME_CYCLES = 10000
) (
  input logic       clk,
  input logic       reset_n,
  input logic       dmaEnable,
  input logic       dirIn,
  input logic [7:0] bufBase,
  input logic [7:0] bufSize,
  input logic       sofPulse,
  input logic       frameNumberLow,
  input logic       ubmWrValid,
  input logic       ubmPacketDone,
  input logic [6:0] ubmSampleCount,
  input logic       ubmInToken,
  input logic       ubmNullPacket,
  input logic       cportRxValid,
  input logic       cportRxBusy,
  input logic [6:0] outCountRegX,
  input logic [6:0] outCountRegY,
  input logic [7:0] inCountRegX,
  input logic [7:0] inCountRegY,
  input logic [7:0] channelByteCount,
  input logic [7:0] rdPtr,
  input logic [7:0] wrPtr
);
  localparam int MARK_AT = FRAME_CYCLES - 1259;
  logic [15:0] sinceSof;
  wire  [7:0]  lastSlot = bufBase + bufSize - 8'h01;
  wire  [7:0]  nextWr   = (wrPtr == lastSlot) ? bufBase : wrPtr + 8'h01;
  wire  [7:0]  nextRd   = (rdPtr == lastSlot) ? bufBase : rdPtr + 8'h01;
  wire  [7:0]  fill     = (wrPtr >= rdPtr) ? wrPtr - rdPtr : wrPtr + bufSize - rdPtr;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Cycles since the last start-of-frame, same origin as the frame timer
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      sinceSof <= 16'h0000;
    else
      sinceSof <= sofPulse ? 16'h0000 : sinceSof + 16'h0001;
  end

  a_ptr_base_load:
    assert property (!dmaEnable |=> rdPtr == $past(bufBase) && wrPtr == $past(bufBase))
    else $error("pointers not loaded with base while halted");
  a_in_flags_init:
    assert property (!dmaEnable |=> inCountRegX == 8'h80 && inCountRegY == 8'h80)
    else $error("in count registers not reinitialised while halted");
  a_wr_step_wrap:
    assert property (dmaEnable && (dirIn ? cportRxValid : ubmWrValid) |=> wrPtr == $past(nextWr))
    else $error("write pointer did not step once with wrap");
  a_rd_step_wrap:
    assert property (dmaEnable && $past(dmaEnable) && $changed(rdPtr) |-> rdPtr == $past(nextRd))
    else $error("read pointer moved other than one step with wrap");
  a_rd_hold_empty:
    assert property (dmaEnable && !dirIn && rdPtr == wrPtr |=> $stable(rdPtr))
    else $error("read pointer moved past write pointer");
  a_out_count_sel:
    assert property (dmaEnable && !dirIn && ubmPacketDone |=>
      ($past(frameNumberLow) ? outCountRegY : outCountRegX) == $past(ubmSampleCount))
    else $error("out sample count stored in wrong register");
  a_byte_count_sof:
    assert property (dmaEnable && sofPulse |=> channelByteCount == $past(fill))
    else $error("byte count not loaded at start-of-frame");
  a_null_answer:
    assert property (dmaEnable && dirIn && ubmInToken && inCountRegX[7] && inCountRegY[7] |=> ubmNullPacket)
    else $error("token with no data not answered by null packet");
  a_mark_publish:
    assert property ($fell(inCountRegX[7]) || $fell(inCountRegY[7]) |-> sinceSof > MARK_AT &&
      !$past(cportRxBusy) && $fell(inCountRegX[7]) == $past(frameNumberLow))
    else $error("in count published at wrong time or register");
endmodule // icbd_chk

bind icbd_top icbd_chk #(.FRAME_CYCLES(FRAME_CYCLES)) chk (.*);

// *** verif/icbd_codec_model.sv ***
// Codec-port partner: free-running frames, stalling transmit, bursty receive
`timescale 1ns/1ns
module icbd_codec_model (
  input  logic       clk,
  input  logic       reset_n,
  input  logic       rxOn,
  output logic       cportFrameStart,
  output logic       cportTxReady,
  output logic       cportRxValid,
  output logic [7:0] cportRxData,
  output logic       cportRxBusy
);
  logic [5:0] phase;
  logic [7:0] rxSeq;
  logic       inFrame;
  logic       rstSeen;
  logic       rxSeen;

  initial begin
    phase = 6'h00;
    rxSeq = 8'h00;
    inFrame = 1'b0;
    {cportFrameStart, cportTxReady, cportRxValid, cportRxBusy} = 4'h0;
    cportRxData = 8'h00;
  end

  always @(posedge clk) begin
    // Inputs taken at the edge, as the design sees them
    rstSeen = reset_n;
    rxSeen  = rxOn;
    #1;
    phase = rstSeen ? phase + 6'h01 : 6'h00;
    if (phase == 6'h00)
      inFrame = rxSeen;
    cportFrameStart = (phase[3:0] == 4'h0); // Frames never pause
    cportTxReady    = phase[1];
    cportRxBusy     = inFrame && (phase < 6'h08);
    cportRxValid    = cportRxBusy && phase[0];
    cportRxData     = cportRxValid ? rxSeq : ~cportRxData;
    if (cportRxValid)
      rxSeq = rxSeq + 8'h01;
  end
endmodule // icbd_codec_model

// *** verif/iso_circular_buffer_dma_tb.sv ***
// Self-checking bench for the isochronous circular-buffer DMA channel
`timescale 1ns/1ns
module iso_circular_buffer_dma_tb;
  localparam int FRAMEC = 1400;
  localparam int MARK   = FRAMEC - (1511 * 10) / 12;
  logic       clk, reset_n, dmaEnable, dirIn, sofPulse, frameNumberLow, rxOn;
  logic       ubmWrValid, ubmPacketDone, ubmInToken, ubmRdValid, ubmInDone, ubmNullPacket;
  logic       cportFrameStart, cportTxReady, cportTxValid, cportRxValid, cportRxBusy;
  logic [7:0] bufBase, bufSize, ubmWrData, ubmRdData, cportTxData, cportRxData;
  logic [7:0] inCountRegX, inCountRegY, channelByteCount, rdPtr, wrPtr, outExp, inExp, wrSeq;
  logic [6:0] ubmSampleCount, outCountRegX, outCountRegY;
  logic [1:0] bytesPerSample;
  int         err_count, cmp_count, rxBytes, rxBase, sinceSof, pubCnt;

  icbd_top #(.FRAME_CYCLES(FRAMEC)) uut (.*);
  icbd_codec_model partner (.*);

  always #50 clk = ~clk;

  // Bytes seen on the codec side, and a frame-relative cycle count
  always @(posedge clk) begin
    sinceSof <= sofPulse ? 0 : sinceSof + 1;
    if (cportRxValid && dmaEnable && dirIn)
      rxBytes <= rxBytes + 1;
    if (cportTxValid && cportTxReady) begin
      check8(cportTxData, outExp);
      outExp <= outExp + 8'h01;
    end
  end

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("compares=%0d mismatches=%0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic sof(input logic fnl);
    frameNumberLow = fnl;
    sofPulse = 1'b1;
    tick(1);
    sofPulse = 1'b0;
  endtask

  task automatic wr_bytes(input int n);
    repeat (n) begin
      ubmWrValid = 1'b1;
      ubmWrData = wrSeq;
      wrSeq = wrSeq + 8'h01;
      tick(1);
    end
    ubmWrValid = 1'b0;
  endtask

  task automatic drain;
    for (int i = 0; i < 300 && rdPtr !== wrPtr; i++)
      tick(1);
    tick(20);
  endtask

  task automatic in_txn(input logic expNull, input int nBytes);
    int   n;
    logic gotNull;
    logic done;
    n = 0;
    done = 1'b0;
    ubmInToken = 1'b1;
    tick(1);
    ubmInToken = 1'b0;
    gotNull = ubmNullPacket;
    for (int i = 0; i < 600 && !done && !gotNull; i++) begin
      tick(1);
      if (ubmRdValid) begin
        check8(ubmRdData, inExp);
        inExp = inExp + 8'h01;
        n++;
      end
      done = ubmInDone;
    end
    check8({7'h00, gotNull}, {7'h00, expNull});
    check8({7'h00, done}, {7'h00, ~expNull});
    if (!expNull)
      check8(n[7:0], nBytes[7:0]);
  endtask

  task automatic wait_pub(input logic selX, input int bps);
    logic [7:0] r;
    r = 8'hFF;
    for (int i = 0; i < 1500 && r[7] !== 1'b0; i++) begin
      tick(1);
      r = selX ? inCountRegX : inCountRegY;
    end
    pubCnt = (rxBytes - rxBase) / bps;
    rxBase = rxBytes;
    check8({7'h00, sinceSof > MARK && sinceSof <= MARK + 9}, 8'h01);
    check8(r, 8'(pubCnt));
  endtask

  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    {dmaEnable, dirIn, sofPulse, frameNumberLow, rxOn, ubmWrValid, ubmPacketDone, ubmInToken} = 8'h00;
    ubmWrData = 8'h00;
    ubmSampleCount = 7'h00;
    bufBase = 8'h10;
    bufSize = 8'h06;
    bytesPerSample = 2'b01;
    {outExp, wrSeq, inExp} = {8'hA0, 8'hA0, 8'h00};
    {err_count, cmp_count, rxBytes, rxBase, sinceSof, pubCnt} = '0;
    repeat (8) @(posedge clk);
    #1 reset_n = 1'b1;
    tick(2);
    check8(rdPtr, 8'h10);
    check8(wrPtr, 8'h10);
    dmaEnable = 1'b1;
    tick(1);
    wr_bytes(4);
    check8(wrPtr, 8'h14);
    tick(40);
    check8({7'h00, cportTxValid}, 8'h00);
    {ubmPacketDone, ubmSampleCount, frameNumberLow} = {1'b1, 7'h05, 1'b1};
    tick(1);
    {ubmSampleCount, frameNumberLow} = {7'h03, 1'b0};
    tick(1);
    ubmPacketDone = 1'b0;
    tick(1);
    check8({1'b0, outCountRegY}, 8'h05);
    check8({1'b0, outCountRegX}, 8'h03);
    sof(1'b0);
    check8(channelByteCount, 8'h04);
    drain();
    check8(outExp, 8'hA4);
    wr_bytes(4);
    check8(wrPtr, 8'h12);
    tick(40);
    check8(rdPtr, 8'h14);
    sof(1'b1);
    check8(channelByteCount, 8'h04);
    drain();
    check8(outExp, 8'hA8);
    $display("OUT streaming test done");
    {dmaEnable, dirIn, bufBase, bufSize} = {1'b0, 1'b1, 8'h40, 8'h40};
    tick(2);
    check8(inCountRegX, 8'h80);
    check8(inCountRegY, 8'h80);
    check8(wrPtr, 8'h40);
    {dmaEnable, rxOn} = 2'b11;
    tick(1);
    sof(1'b1);
    wait_pub(1'b1, 2);
    check8(inCountRegY, 8'h80);
    rxOn = 1'b0;
    in_txn(1'b1, 0);
    sof(1'b0);
    in_txn(1'b0, 2 * pubCnt);
    check8(inCountRegX & 8'h80, 8'h80);
    in_txn(1'b1, 0);
    rxOn = 1'b1;
    wait_pub(1'b0, 2);
    rxOn = 1'b0;
    sof(1'b1);
    in_txn(1'b0, 2 * pubCnt);
    $display("IN ping-pong test done");
    {dmaEnable, bytesPerSample} = {1'b0, 2'b00};
    tick(2);
    {dmaEnable, rxOn} = 2'b11;
    rxBase = rxBytes;
    tick(1);
    sof(1'b1);
    wait_pub(1'b1, 1);
    rxOn = 1'b0;
    sof(1'b0);
    in_txn(1'b0, pubCnt);
    $display("IN one-byte sample test done");
    report_and_stop();
  end

  // Whole run is under 1000 cycles; allow twenty times that
  initial begin
    #(20000 * 100);
    err_count++;
    report_and_stop();
  end
endmodule // iso_circular_buffer_dma_tb
